// *** core/afe_ctrl_regs.sv ***
// front-end control register bank with wishbone slave and result registers
//
// Behaviour
// - regulator level code drives one-hot level select
// - regulator bit enables; cleared asserts weak pull-down
// - power bit 2 enables regulator bypass path
// - common-mode bit enables; cleared floats output pin
// - common-mode bit 6 always reads zero
// - four switch bits, reset pattern 1010
// - reference gain: one, half, quarter, reserved
// - converter gain: one, two, four, reserved
// - amplifier gain code is power of two
// - gain bit 7 always reads zero
// - input bit 7 bypasses and disables amplifier
// - input bit 6 shorts the selected inputs
// - input bits 5..4 pick differential routing
// - three read-only result bytes hold 24-bit value
// - decimating filter feeds the result registers
// - offset code: sign bit plus quarter steps
// - input bit 0 always reads zero
//
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "afe_map.svh"

module afe_ctrl_regs (
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    input  wire logic        CE_I,
    // wishbone classic slave
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic [31:0]      DAT_O,
    output logic             ACK_O,
    // modulator stream
    input  wire logic        MOD_BIT_I,
    // analog controls
    output logic             REG_ON_O,
    output logic             REG_PULLDOWN_O,
    output logic             REG_BYPASS_O,
    output logic [3:0]       REG_LEVEL_O,
    output logic             CM_ON_O,
    output logic             CM_DRIVE_O,
    output logic [3:0]       AMP_SW_O,
    output logic [2:0]       REF_GAIN_O,
    output logic [2:0]       CONV_GAIN_O,
    output logic [7:0]       AMP_GAIN_O,
    output logic             AMP_ON_O,
    output logic             AMP_BYPASS_O,
    output logic             INPUTS_SHORT_O,
    output logic [1:0]       INPUT_ROUTING_O,
    output logic [1:0]       OFFSET_STEPS_O,
    output logic             OFFSET_NEG_O
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // keep unmapped bits of a register, take masked bits from the write
    function automatic afe_pkg::afe_byte_t afe_merge(input afe_pkg::afe_byte_t old_v,
                                                     input afe_pkg::afe_byte_t new_v,
                                                     input afe_pkg::afe_byte_t mask);
        afe_merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    // two-bit code to one-hot over four taps
    function automatic logic [3:0] afe_onehot4(input logic [1:0] code);
        afe_onehot4 = 4'h1 << code;
    endfunction

    // two-bit code to three taps; code 11 shifts out and opens every tap
    function automatic logic [2:0] afe_onehot3(input logic [1:0] code);
        afe_onehot3 = 3'h1 << code;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    afe_pkg::afe_bus_state_t bus_state, next_bus_state;
    afe_pkg::afe_byte_t      power_ctl, cm_ctl, gain_ctl, input_ctl;
    afe_pkg::afe_byte_t      next_power_ctl, next_cm_ctl, next_gain_ctl, next_input_ctl;
    logic [23:0]             result, next_result;
    logic                    ready, next_ready;
    logic                    overrun, next_overrun;
    logic [31:0]             next_dat;
    logic [7:0]              word_adr;
    logic                    wr_lane0;
    logic [23:0]             filt_result;
    logic                    filt_valid;
    logic                    next_reg_on, next_reg_pd, next_reg_bps;
    logic [3:0]              next_reg_level;
    logic                    next_cm_on, next_cm_drive;
    logic [3:0]              next_amp_sw;
    logic [2:0]              next_ref_gain, next_conv_gain;
    logic [7:0]              next_amp_gain;
    logic                    next_amp_on, next_amp_bps, next_short;
    logic [1:0]              next_routing, next_steps;
    logic                    next_neg;
    logic [2:0]              ofs_code;

    ////////////////////////////////////////////////////////////////////////////
    // decimating filter
    // shares ce_i, so a frozen block samples no modulator bits
    // it runs whether or not software reads the results
    afe_sinc_filter u_filter (
        .clk_i    (CLK_I),
        .rst_i    (RST_I),
        .ce_i     (CE_I),
        .bit_i    (MOD_BIT_I),
        .result_o (filt_result),
        .valid_o  (filt_valid)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: accept in idle, answer one cycle later with a one-cycle ack
    // idle again after ack, so the next request is taken at once
    // ce_i low holds ack but lands nothing; keep it high across a cycle
    assign word_adr = {ADR_I[7:2], 2'b00};
    assign wr_lane0 = (bus_state == afe_pkg::AFE_BUS_ACK) & WE_I & SEL_I[0];
    assign ACK_O    = (bus_state == afe_pkg::AFE_BUS_ACK);   // held one cycle while ce_i is high

    always_comb begin
        next_bus_state = bus_state;
        unique case (bus_state)
            afe_pkg::AFE_BUS_IDLE: begin
                if (CYC_I && STB_I) begin
                    next_bus_state = afe_pkg::AFE_BUS_ACK;
                end
            end
            afe_pkg::AFE_BUS_ACK: begin
                next_bus_state = afe_pkg::AFE_BUS_IDLE;
            end
            default: begin
                next_bus_state = afe_pkg::AFE_BUS_IDLE;
            end
        endcase
    end

    // read data is captured on acceptance; unmapped words read zero
    // loading at acceptance gives decode a full cycle before ack
    // unmapped words answer normally, never with an error
    always_comb begin
        next_dat = DAT_O;
        if (bus_state == afe_pkg::AFE_BUS_IDLE && CYC_I && STB_I && !WE_I) begin
            next_dat = 32'h00000000;
            case (word_adr)
                `AFE_OFS_POWER:    next_dat[7:0] = power_ctl;
                `AFE_OFS_CM:       next_dat[7:0] = cm_ctl & `AFE_MASK_CM;
                `AFE_OFS_GAIN:     next_dat[7:0] = gain_ctl & `AFE_MASK_GAIN;
                `AFE_OFS_INPUT:    next_dat[7:0] = input_ctl & `AFE_MASK_INPUT;
                `AFE_OFS_RES_LOW:  next_dat[7:0] = result[7:0];
                `AFE_OFS_RES_MID:  next_dat[7:0] = result[15:8];
                `AFE_OFS_RES_HIGH: next_dat[7:0] = result[23:16];
                `AFE_OFS_STATUS:   next_dat[1:0] = {overrun, ready};
                default:           next_dat      = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers: writes land on the edge that carries ack.
    // reserved power bits and common-mode bits 5..4 are stored as written, so software
    // that breaks the all-zero convention sees its own value back
    // only byte lane 0 holds register bits
    always_comb begin
        next_power_ctl = power_ctl;
        next_cm_ctl    = cm_ctl;
        next_gain_ctl  = gain_ctl;
        next_input_ctl = input_ctl;
        if (wr_lane0) begin
            case (word_adr)
                `AFE_OFS_POWER: next_power_ctl = afe_merge(power_ctl, DAT_I[7:0],
                                                           `AFE_MASK_POWER);
                `AFE_OFS_CM:    next_cm_ctl    = afe_merge(cm_ctl, DAT_I[7:0],
                                                           `AFE_MASK_CM);
                `AFE_OFS_GAIN:  next_gain_ctl  = afe_merge(gain_ctl, DAT_I[7:0],
                                                           `AFE_MASK_GAIN);
                `AFE_OFS_INPUT: next_input_ctl = afe_merge(input_ctl, DAT_I[7:0],
                                                           `AFE_MASK_INPUT);
                default:        next_power_ctl = power_ctl;  // result bytes ignore writes
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result capture and status; a new result beats a same-cycle clear
    // status: bit 0 ready, bit 1 overrun, writing one clears
    // result bytes are not latched together; overrun tells software
    always_comb begin
        next_result  = result;
        next_ready   = ready;
        next_overrun = overrun;
        if (wr_lane0 && word_adr == `AFE_OFS_STATUS) begin
            if (DAT_I[`AFE_STAT_READY_BIT]) begin
                next_ready = 1'b0;
            end
            if (DAT_I[`AFE_STAT_OVR_BIT]) begin
                next_overrun = 1'b0;
            end
        end
        if (filt_valid) begin
            next_result = filt_result;
            next_ready  = 1'b1;
            if (ready) begin
                next_overrun = 1'b1;   // previous result was never acknowledged
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // analog control decode, registered so the pins never glitch
    always_comb begin
        // pull-down is always the inverse of the regulator enable
        next_reg_on    = power_ctl[`AFE_POWER_ON_BIT];
        next_reg_pd    = ~power_ctl[`AFE_POWER_ON_BIT];
        next_reg_bps   = power_ctl[`AFE_POWER_BPS_BIT];
        next_reg_level = afe_onehot4(power_ctl[`AFE_POWER_LVL_LSB+1:`AFE_POWER_LVL_LSB]);
        next_cm_on     = cm_ctl[`AFE_CM_ON_BIT];
        next_cm_drive  = cm_ctl[`AFE_CM_ON_BIT];
        next_amp_sw    = cm_ctl[`AFE_CM_SW_LSB+3:`AFE_CM_SW_LSB];

        // reserved code 11 selects no gain tap at all
        next_ref_gain  = afe_onehot3(gain_ctl[`AFE_GAIN_REF_LSB+1:`AFE_GAIN_REF_LSB]);
        next_conv_gain = afe_onehot3(gain_ctl[`AFE_GAIN_CONV_LSB+1:`AFE_GAIN_CONV_LSB]);

        // amplifier: bypass and enable always opposite
        next_amp_gain  = 8'h01 << gain_ctl[`AFE_GAIN_AMP_LSB+2:`AFE_GAIN_AMP_LSB];
        next_amp_on    = ~input_ctl[`AFE_IN_BPS_BIT];
        next_amp_bps   = input_ctl[`AFE_IN_BPS_BIT];
        next_short     = input_ctl[`AFE_IN_SHORT_BIT];
        next_routing   = input_ctl[`AFE_IN_ROUTE_LSB+1:`AFE_IN_ROUTE_LSB];

        // offset: two step bits, top bit is the sign
        // code 100 repeats zero, so it never reads negative
        ofs_code       = input_ctl[`AFE_IN_OFS_LSB+2:`AFE_IN_OFS_LSB];
        next_steps     = ofs_code[1:0];
        next_neg       = ofs_code[2] & (ofs_code[1:0] != 2'b00);  // 100 is plain zero
    end

    ////////////////////////////////////////////////////////////////////////////
    // all state registers; clock enable low freezes everything
    // outputs reset to the decode of the register reset values,
    // so no output moves at the first edge after release
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            bus_state       <= afe_pkg::AFE_BUS_IDLE;
            DAT_O           <= 32'h00000000;
            power_ctl       <= `AFE_RST_POWER;
            cm_ctl          <= `AFE_RST_CM;
            gain_ctl        <= `AFE_RST_GAIN;
            input_ctl       <= `AFE_RST_INPUT;
            result          <= 24'h000000;
            ready           <= 1'b0;
            overrun         <= 1'b0;
            REG_ON_O        <= 1'b0;
            REG_PULLDOWN_O  <= 1'b1;
            REG_BYPASS_O    <= 1'b0;
            REG_LEVEL_O     <= 4'h1;
            CM_ON_O         <= 1'b0;
            CM_DRIVE_O      <= 1'b0;
            AMP_SW_O        <= 4'ha;
            REF_GAIN_O      <= 3'h1;
            CONV_GAIN_O     <= 3'h1;
            AMP_GAIN_O      <= 8'h01;
            AMP_ON_O        <= 1'b1;
            AMP_BYPASS_O    <= 1'b0;
            INPUTS_SHORT_O  <= 1'b0;
            INPUT_ROUTING_O <= 2'h0;
            OFFSET_STEPS_O  <= 2'h0;
            OFFSET_NEG_O    <= 1'b0;
        end else if (CE_I) begin
            bus_state       <= next_bus_state;
            DAT_O           <= next_dat;
            power_ctl       <= next_power_ctl;
            cm_ctl          <= next_cm_ctl;
            gain_ctl        <= next_gain_ctl;
            input_ctl       <= next_input_ctl;
            result          <= next_result;
            ready           <= next_ready;
            overrun         <= next_overrun;
            REG_ON_O        <= next_reg_on;
            REG_PULLDOWN_O  <= next_reg_pd;
            REG_BYPASS_O    <= next_reg_bps;
            REG_LEVEL_O     <= next_reg_level;
            CM_ON_O         <= next_cm_on;
            CM_DRIVE_O      <= next_cm_drive;
            AMP_SW_O        <= next_amp_sw;
            REF_GAIN_O      <= next_ref_gain;
            CONV_GAIN_O     <= next_conv_gain;
            AMP_GAIN_O      <= next_amp_gain;
            AMP_ON_O        <= next_amp_on;
            AMP_BYPASS_O    <= next_amp_bps;
            INPUTS_SHORT_O  <= next_short;
            INPUT_ROUTING_O <= next_routing;
            OFFSET_STEPS_O  <= next_steps;
            OFFSET_NEG_O    <= next_neg;
        end
    end

endmodule // afe_ctrl_regs

// *** core/afe_map.svh ***
// register map, field positions, reset values and counts of the front-end control bank
`ifndef AFE_MAP_SVH
`define AFE_MAP_SVH

// byte addresses on the register bus, one aligned 32-bit word each
`define AFE_OFS_POWER      8'h00
`define AFE_OFS_CM         8'h04
`define AFE_OFS_GAIN       8'h08
`define AFE_OFS_INPUT      8'h0c
`define AFE_OFS_RES_LOW    8'h10
`define AFE_OFS_RES_MID    8'h14
`define AFE_OFS_RES_HIGH   8'h18
`define AFE_OFS_STATUS     8'h1c

// power-on values
`define AFE_RST_POWER      8'h00
`define AFE_RST_CM         8'h0a
`define AFE_RST_GAIN       8'h00
`define AFE_RST_INPUT      8'h00

// bits that hold storage; the rest read as zero and ignore writes
`define AFE_MASK_POWER     8'hff
`define AFE_MASK_CM        8'hbf
`define AFE_MASK_GAIN      8'h7f
`define AFE_MASK_INPUT     8'hfe

// regulator power control fields
`define AFE_POWER_ON_BIT   7
`define AFE_POWER_BPS_BIT  2
`define AFE_POWER_LVL_LSB  0

// common-mode control fields
`define AFE_CM_ON_BIT      7
`define AFE_CM_SW_LSB      0

// gain select fields
`define AFE_GAIN_REF_LSB   5
`define AFE_GAIN_CONV_LSB  3
`define AFE_GAIN_AMP_LSB   0

// input connection fields
`define AFE_IN_BPS_BIT     7
`define AFE_IN_SHORT_BIT   6
`define AFE_IN_ROUTE_LSB   4
`define AFE_IN_OFS_LSB     1

// status fields
`define AFE_STAT_READY_BIT 0
`define AFE_STAT_OVR_BIT   1

// decimation: 2**8 modulator bits per result
`define AFE_DECIM_LOG2     8
`define AFE_DECIM_LAST     8'hff

`endif

// *** core/afe_pkg.sv ***
// types shared by the front-end control bank and its filter
package afe_pkg;

    // bus slave states, one-hot
    typedef enum logic [1:0] {
        AFE_BUS_IDLE = 2'b01,
        AFE_BUS_ACK  = 2'b10
    } afe_bus_state_t;

    typedef logic [7:0]  afe_byte_t;
    typedef logic [24:0] afe_acc_t;

endpackage

// *** core/afe_sinc_filter.sv ***
// third-order decimating filter turning the modulator bit stream into 24-bit results
`timescale 1ns/1ps
`include "afe_map.svh"

module afe_sinc_filter (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        bit_i,
    output logic [23:0]      result_o,
    output logic             valid_o
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    afe_pkg::afe_acc_t integ1, integ2, integ3;
    afe_pkg::afe_acc_t dly1, dly2, dly3;
    afe_pkg::afe_acc_t next_integ1, next_integ2, next_integ3;
    afe_pkg::afe_acc_t next_dly1, next_dly2, next_dly3;
    afe_pkg::afe_acc_t comb1, comb2, comb3;
    logic [7:0]        phase, next_phase;
    logic [23:0]       next_result;
    logic              next_valid;

    ////////////////////////////////////////////////////////////////////////////
    // integrators run every sample; combs run once per decimation frame.
    // wrap-around arithmetic is exact because the full-scale sum 2**24 fits 25 bits
    always_comb begin
        next_integ1 = integ1 + {24'h000000, bit_i};
        next_integ2 = integ2 + integ1;
        next_integ3 = integ3 + integ2;
        next_phase  = phase + 8'h01;
        comb1       = integ3 - dly1;
        comb2       = comb1 - dly2;
        comb3       = comb2 - dly3;
        next_dly1   = dly1;
        next_dly2   = dly2;
        next_dly3   = dly3;
        next_result = result_o;
        next_valid  = 1'b0;
        if (phase == `AFE_DECIM_LAST) begin
            next_dly1   = integ3;
            next_dly2   = comb1;
            next_dly3   = comb2;
            next_valid  = 1'b1;
            // an all-ones stream reaches 2**24; clamp it to full scale
            next_result = comb3[24] ? 24'hffffff : comb3[23:0];
        end
    end

    // registers only; clock enable freezes the whole filter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            integ1   <= '0;
            integ2   <= '0;
            integ3   <= '0;
            dly1     <= '0;
            dly2     <= '0;
            dly3     <= '0;
            phase    <= 8'h00;
            result_o <= 24'h000000;
            valid_o  <= 1'b0;
        end else if (ce_i) begin
            integ1   <= next_integ1;
            integ2   <= next_integ2;
            integ3   <= next_integ3;
            dly1     <= next_dly1;
            dly2     <= next_dly2;
            dly3     <= next_dly3;
            phase    <= next_phase;
            result_o <= next_result;
            valid_o  <= next_valid;
        end
    end

endmodule // afe_sinc_filter

// *** verif/afe_ctrl_props.sv ***
// concurrent checks on the front-end control bank ports
`timescale 1ns/1ps
`include "afe_map.svh"

module afe_ctrl_props (
    input wire logic        CLK_I,
    input wire logic        RST_I,
    input wire logic        CE_I,
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        WE_I,
    input wire logic [7:0]  ADR_I,
    input wire logic [3:0]  SEL_I,
    input wire logic [31:0] DAT_I,
    input wire logic [31:0] DAT_O,
    input wire logic        ACK_O,
    input wire logic        REG_ON_O,
    input wire logic        REG_PULLDOWN_O,
    input wire logic        REG_BYPASS_O,
    input wire logic [3:0]  REG_LEVEL_O,
    input wire logic        CM_ON_O,
    input wire logic        CM_DRIVE_O,
    input wire logic [2:0]  REF_GAIN_O,
    input wire logic [2:0]  CONV_GAIN_O,
    input wire logic [7:0]  AMP_GAIN_O,
    input wire logic        AMP_ON_O,
    input wire logic        AMP_BYPASS_O,
    input wire logic [1:0]  OFFSET_STEPS_O,
    input wire logic        OFFSET_NEG_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    ////////////////////////////////////////////////////////////////////////////
    // a request that the idle slave takes at this edge
    sequence s_take;
        CYC_I && STB_I && !ACK_O && CE_I;
    endsequence
    // a byte-enabled write to the power word
    sequence s_wr_power;
        s_take ##0 (WE_I && SEL_I[0] && (ADR_I & 8'hfc) == `AFE_OFS_POWER);
    endsequence
    // bus update lands one edge after ack, outputs one edge later still
    property p_power_lands;
        s_wr_power |=> ##2 (REG_ON_O == $past(DAT_I[7], 3) &&
            REG_BYPASS_O == $past(DAT_I[2], 3) &&
            REG_LEVEL_O == (4'h1 << $past(DAT_I[1:0], 3)));
    endproperty

    ////////////////////////////////////////////////////////////////////////////
    chk_ack_after_take: assert property (s_take |=> ACK_O)
        else $error("ack missing after a taken request");
    chk_ack_single: assert property (ACK_O |=> !ACK_O)
        else $error("ack held longer than one cycle");
    chk_power_lands: assert property (p_power_lands)
        else $error("power controls do not follow the written word");
    chk_pulldown_inverse: assert property (REG_PULLDOWN_O == !REG_ON_O)
        else $error("pull-down not the inverse of regulator enable");
    chk_level_onehot: assert property ($onehot(REG_LEVEL_O))
        else $error("level select not one-hot");
    chk_cm_drive: assert property (CM_DRIVE_O == CM_ON_O)
        else $error("common-mode drive differs from enable");
    chk_amp_gain_onehot: assert property ($onehot(AMP_GAIN_O))
        else $error("amplifier gain not one-hot");
    chk_gain_sel_onehot: assert property ($onehot0(REF_GAIN_O) && $onehot0(CONV_GAIN_O))
        else $error("reference or converter gain has several bits set");
    chk_amp_bypass: assert property (AMP_ON_O != AMP_BYPASS_O)
        else $error("amplifier on and bypass agree");
    chk_offset_sign: assert property (OFFSET_NEG_O |-> OFFSET_STEPS_O != 2'h0)
        else $error("negative offset with zero steps");
    // unimplemented positions read zero in every control word
    chk_unimpl_zero: assert property (ACK_O && !WE_I && ADR_I[7:4] == 4'h0 |->
        DAT_O[31:8] == 24'h0 && !(ADR_I[3:2] == 2'h1 && DAT_O[6]) &&
        !(ADR_I[3:2] == 2'h2 && DAT_O[7]) && !(ADR_I[3:2] == 2'h3 && DAT_O[0]))
        else $error("unimplemented bit read as one");
endmodule // afe_ctrl_props

bind afe_ctrl_regs afe_ctrl_props u_props (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I),
    .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
    .DAT_O(DAT_O), .ACK_O(ACK_O), .REG_ON_O(REG_ON_O), .REG_PULLDOWN_O(REG_PULLDOWN_O),
    .REG_BYPASS_O(REG_BYPASS_O), .REG_LEVEL_O(REG_LEVEL_O), .CM_ON_O(CM_ON_O),
    .CM_DRIVE_O(CM_DRIVE_O), .REF_GAIN_O(REF_GAIN_O), .CONV_GAIN_O(CONV_GAIN_O),
    .AMP_GAIN_O(AMP_GAIN_O), .AMP_ON_O(AMP_ON_O), .AMP_BYPASS_O(AMP_BYPASS_O),
    .OFFSET_STEPS_O(OFFSET_STEPS_O), .OFFSET_NEG_O(OFFSET_NEG_O));

// *** verif/tb_top.sv ***
// self-checking bench for the front-end control register bank
`timescale 1ns/1ps
`include "afe_map.svh"

module tb_top;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r;} afe_row_t;
    logic        CLK_I, RST_I, CE_I, CYC_I, STB_I, WE_I, MOD_BIT_I, ACK_O;
    logic        REG_ON_O, REG_PULLDOWN_O, REG_BYPASS_O, CM_ON_O, CM_DRIVE_O;
    logic        AMP_ON_O, AMP_BYPASS_O, INPUTS_SHORT_O, OFFSET_NEG_O;
    logic [7:0]  ADR_I, AMP_GAIN_O;
    logic [3:0]  SEL_I, REG_LEVEL_O, AMP_SW_O;
    logic [2:0]  REF_GAIN_O, CONV_GAIN_O, k, g;
    logic [1:0]  INPUT_ROUTING_O, OFFSET_STEPS_O, c;
    logic [31:0] DAT_I, DAT_O, rd;
    int          fails, checks_done;
    // all control outputs in one word so one compare covers them
    wire [34:0]  outs = {REG_ON_O, REG_PULLDOWN_O, REG_BYPASS_O, REG_LEVEL_O, CM_ON_O,
        CM_DRIVE_O, AMP_SW_O, REF_GAIN_O, CONV_GAIN_O, AMP_GAIN_O, AMP_ON_O, AMP_BYPASS_O,
        INPUTS_SHORT_O, INPUT_ROUTING_O, OFFSET_STEPS_O, OFFSET_NEG_O};
    localparam logic [34:0] RST_OUTS = {3'h2, 4'h1, 2'h0, 4'ha, 3'h1, 3'h1, 8'h01, 8'h80};
    // write then read back; unmapped and upper bits must vanish
    afe_row_t rows [5] = '{'{`AFE_OFS_POWER, 32'h87, 32'h87}, '{`AFE_OFS_CM, 32'hcf, 32'h8f},
        '{`AFE_OFS_GAIN, 32'hff, 32'h7f}, '{`AFE_OFS_INPUT, 32'hff, 32'hfe},
        '{8'h20, 32'hff, 32'h0}};

    afe_ctrl_regs uut (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .CYC_I(CYC_I),
        .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
        .DAT_O(DAT_O), .ACK_O(ACK_O), .MOD_BIT_I(MOD_BIT_I), .REG_ON_O(REG_ON_O),
        .REG_PULLDOWN_O(REG_PULLDOWN_O), .REG_BYPASS_O(REG_BYPASS_O),
        .REG_LEVEL_O(REG_LEVEL_O), .CM_ON_O(CM_ON_O), .CM_DRIVE_O(CM_DRIVE_O),
        .AMP_SW_O(AMP_SW_O), .REF_GAIN_O(REF_GAIN_O), .CONV_GAIN_O(CONV_GAIN_O),
        .AMP_GAIN_O(AMP_GAIN_O), .AMP_ON_O(AMP_ON_O), .AMP_BYPASS_O(AMP_BYPASS_O),
        .INPUTS_SHORT_O(INPUTS_SHORT_O), .INPUT_ROUTING_O(INPUT_ROUTING_O),
        .OFFSET_STEPS_O(OFFSET_STEPS_O), .OFFSET_NEG_O(OFFSET_NEG_O));

    ////////////////////////////////////////////////////////////////////////////
    // compare and count; case inequality so unknowns never match
    task automatic check(input string n, input logic [39:0] seen, input logic [39:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // one classic cycle; held until ack is sampled, then released for a cycle
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] w,
                      input logic [3:0] s, output logic [31:0] d);
        int n;
        CYC_I <= 1'h1;
        STB_I <= 1'h1;
        WE_I <= we;
        ADR_I <= a;
        DAT_I <= w;
        SEL_I <= s;
        n = 0;
        do begin
            @(posedge CLK_I);
            n++;
        end while (ACK_O !== 1'h1 && n < 16);
        d = DAT_O;
        check("ack", ACK_O, 1'h1);
        CYC_I <= 1'h0;
        STB_I <= 1'h0;
        WE_I <= 1'h0;
        @(posedge CLK_I);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        CLK_I = 1'h0;
        forever #50 CLK_I = ~CLK_I;
    end

    // the whole run needs about 3000 cycles
    initial begin
        repeat (20000) @(posedge CLK_I);
        fails++;
        $display("[FAIL] watchdog expected done seen timeout");
        conclude();
    end

    initial begin
        {CE_I, MOD_BIT_I, RST_I} = 3'h7;
        {CYC_I, STB_I, WE_I, ADR_I, SEL_I, DAT_I} = '0;
        fails = 0;
        checks_done = 0;
        repeat (2) @(posedge CLK_I);
        RST_I <= 1'h0;
        @(posedge CLK_I);
        check("reset outputs", outs, RST_OUTS);
        for (int i = 0; i < 4; i++) begin
            wb(1'h0, 8'(i * 4), 32'h0, 4'hf, rd);
            check("reset word", rd, (i == 1) ? 32'ha : 32'h0);
        end
        foreach (rows[i]) begin
            wb(1'h1, rows[i].a, rows[i].w, 4'h1, rd);
            wb(1'h0, rows[i].a, 32'h0, 4'hf, rd);
            check("readback", rd, rows[i].r);
        end
        // a disabled byte lane must leave the stored value alone
        wb(1'h1, `AFE_OFS_POWER, 32'h0, 4'he, rd);
        wb(1'h0, `AFE_OFS_POWER, 32'h0, 4'hf, rd);
        check("lane off", rd, 32'h87);
        // every code of every field except the switch bits (8 of 16 codes), decoded at the outputs
        for (int i = 0; i < 8; i++) begin
            k = 3'(i);
            c = k[1:0];
            g = (c == 2'h3) ? 3'h0 : 3'(1 << c);
            wb(1'h1, `AFE_OFS_POWER, {24'h0, k[0], 4'h0, k[1], c}, 4'h1, rd);
            wb(1'h1, `AFE_OFS_CM, {24'h0, k[1], 3'h0, ~k, k[0]}, 4'h1, rd);
            wb(1'h1, `AFE_OFS_GAIN, {24'h0, 1'h0, c, c, k}, 4'h1, rd);
            wb(1'h1, `AFE_OFS_INPUT, {24'h0, k[0], k[1], c, k, 1'h0}, 4'h1, rd);
            @(posedge CLK_I);
            check("controls", outs, {k[0], !k[0], k[1], 4'(1 << c), k[1], k[1], ~k, k[0],
                g, g, 8'(1 << k), !k[0], k[0], k[1], c, c, k[2] && c != 2'h0});
        end
        // a steady all-ones stream settles to full scale in all three bytes
        repeat (1100) @(posedge CLK_I);
        wb(1'h1, `AFE_OFS_RES_HIGH, 32'h0, 4'hf, rd);
        for (int i = 0; i < 3; i++) begin
            wb(1'h0, 8'(`AFE_OFS_RES_LOW + i * 4), 32'h0, 4'hf, rd);
            check("result ones", rd, 32'hff);
        end
        MOD_BIT_I <= 1'h0;
        repeat (1100) @(posedge CLK_I);
        for (int i = 0; i < 3; i++) begin
            wb(1'h0, 8'(`AFE_OFS_RES_LOW + i * 4), 32'h0, 4'hf, rd);
            check("result zeros", rd, 32'h0);
        end
        wb(1'h0, `AFE_OFS_STATUS, 32'h0, 4'hf, rd);
        check("status late", rd, 32'h3);
        // reset in mid-run restores every power-on value
        RST_I <= 1'h1;
        repeat (2) @(posedge CLK_I);
        RST_I <= 1'h0;
        @(posedge CLK_I);
        check("rerun outputs", outs, RST_OUTS);
        wb(1'h0, `AFE_OFS_CM, 32'h0, 4'hf, rd);
        check("rerun switches", rd, 32'ha);
        wb(1'h0, `AFE_OFS_STATUS, 32'h0, 4'hf, rd);
        check("status reset", rd, 32'h0);
        repeat (300) @(posedge CLK_I);
        wb(1'h0, `AFE_OFS_STATUS, 32'h0, 4'hf, rd);
        check("status ready", rd, 32'h1);
        wb(1'h1, `AFE_OFS_STATUS, 32'h1, 4'h1, rd);
        // enable low must hold the filter past its next result
        CE_I <= 1'h0;
        repeat (300) @(posedge CLK_I);
        CE_I <= 1'h1;
        wb(1'h0, `AFE_OFS_STATUS, 32'h0, 4'hf, rd);
        check("status frozen", rd, 32'h0);
        conclude();
    end
endmodule // tb_top
